// ==== verilog/socket_regs_pkg.sv ====
// package: offsets, field positions and types of the socket register bank
package socket_regs_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_EVENT   = 8'h00; // latched socket events
    localparam logic [7:0] OFF_ENABLE  = 8'h04; // interrupt enables
    localparam logic [7:0] OFF_LIVE    = 8'h08; // live socket state
    localparam logic [7:0] OFF_SIM     = 8'h0c; // event simulate
    localparam logic [7:0] OFF_CTRL    = 8'h10; // socket control
    localparam logic [7:0] OFF_RSV_LO  = 8'h14; // reserved span start
    localparam logic [7:0] OFF_RSV_HI  = 8'h1f; // reserved span end
    localparam logic [7:0] OFF_CLK     = 8'h20; // card clock control

    // event and enable field positions
    localparam int EV_PWR  = 3;                 // power cycle completed
    localparam int EV_CD2  = 2;                 // second card detect
    localparam int EV_CD1  = 1;                 // first card detect
    localparam int EV_CSTS = 0;                 // card status change
    localparam int EV_W    = 4;                 // implemented width

    // live state field positions
    localparam int LS_CAP3  = 29;               // socket supplies 3.3v
    localparam int LS_CAP5  = 28;               // socket supplies 5v
    localparam int LS_CARD3 = 11;               // card accepts 3.3v
    localparam int LS_CARD5 = 10;               // card accepts 5v
    localparam int LS_PWR   = 3;                // interface powered
    localparam int LS_CD2   = 2;                // second detect pin
    localparam int LS_CD1   = 1;                // first detect pin
    localparam int LS_CSTS  = 0;                // status change pin

    // reset values and codes
    localparam logic [31:0] EV_RESET  = 32'h0000_0000;
    localparam logic [3:0]  EN_RESET  = 4'h0;
    localparam logic [31:0] LS_RESET  = 32'h0000_0000;
    localparam logic [1:0]  EN_CD_ON  = 2'h3;   // both detect irqs on
    localparam logic [1:0]  SYNC_FILL = 2'h3;   // edges until live holds pins

    // socket pins as they arrive from the card connector
    typedef struct packed {
        logic cd1_n;                            // first card detect
        logic cd2_n;                            // second card detect
        logic cstschg;                          // card status change
        logic vs1;                              // voltage sense 1
        logic vs2;                              // voltage sense 2
    } card_pins_t;

endpackage : socket_regs_pkg

// ==== verilog/socket_event_regs.sv ====
// socket event, interrupt enable and live state registers behind apb
//
// Function
// - fixed register offsets 00h to 20h
// - power cycle done sets event bit 3
// - second detect change sets event bit 2
// - first detect change sets event bit 1
// - status pin change sets event bit 0
// - event flags write-one-clear, zero after reset
// - event and enable registers reset to zero
// - latched events raise interrupt unless masked
// - enable bit 3 gates power cycle interrupt
// - enable bits 2:1 gate detect interrupts
// - masked detect changes still latch events
// - enable bit 0 gates status change interrupt
// - card removal clears enable bit 0
// - enable bits 31:4 read zero
// - live state read-only, resets zero
// - live bit 29 shows 3.3v supply
// - live bit 28 shows 5v supply
// - live bit 11 card accepts 3.3v
// - live bit 10 card accepts 5v
// - never apply 5v to cardbus card
// - live bit 0 shows status pin
// - live bits 2:1 show detect pins
// - live bit 3 shows interface powered
module socket_event_regs
(
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    // apb slave
    input  wire logic [7:0]                    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // card connector pins, asynchronous
    input  wire socket_regs_pkg::card_pins_t   pins,
    // power and card type from the socket logic, same clock
    input  wire logic                          pwr_cycle_done,
    input  wire logic                          pwr_is_up,
    input  wire logic                          sock_cap_3v3,
    input  wire logic                          sock_cap_5v,
    input  wire logic                          cardbus_card,
    input  wire logic                          vcc_5v_req,
    // socket outputs
    output logic                               status_irq,
    output logic                               vcc_5v_en
);

    socket_regs_pkg::card_pins_t pins_meta;    // first sync stage
    socket_regs_pkg::card_pins_t pins_sync;    // second sync stage
    logic [3:0]                  event_flags;  // latched events
    logic [3:0]                  irq_en;       // interrupt enables
    logic [31:0]                 live_state;   // live state register
    logic [31:0]                 next_live;    // live state to load
    logic                        primed;       // live compares real pins
    logic [1:0]                  warm;         // edges since reset release
    logic [3:0]                  ev_set;       // hardware event sets
    logic [3:0]                  ev_clr;       // software clears
    logic [3:0]                  irq_gate;     // enable per event
    logic                        removal;      // card left socket
    logic                        wr_acc;       // write access phase
    logic                        setup;        // setup phase

    // true when the bus address hits the given register
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // true for any word address inside the register space
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= socket_regs_pkg::OFF_CLK) && (a[1:0] == 2'h0);
    endfunction : mapped

    // card voltage from sense and detect pins: {3.3v, 5v}
    function automatic logic [1:0] card_volts(
        input socket_regs_pkg::card_pins_t p);
        logic present;
        present = ~p.cd1_n & ~p.cd2_n;
        card_volts = {present & ~p.vs1, present & p.vs2};
    endfunction : card_volts

    // bus phase decode; zero wait states
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign pready  = psel & penable;

    // two-stage synchroniser for the connector pins
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pins_meta <= '0;
            pins_sync <= '0;
        end
        else
        begin
            pins_meta <= pins;
            pins_sync <= pins_meta;
        end
    end

    // assemble live state; reserved bits stay zero
    always_comb
    begin
        logic [1:0] volts;
        volts     = card_volts(pins_sync);
        next_live = socket_regs_pkg::LS_RESET;
        next_live[socket_regs_pkg::LS_CAP3]  = sock_cap_3v3;
        next_live[socket_regs_pkg::LS_CAP5]  = sock_cap_5v;
        next_live[socket_regs_pkg::LS_CARD3] = volts[1];
        // 5v never offered for a cardbus card
        next_live[socket_regs_pkg::LS_CARD5] =
            volts[0] & ~cardbus_card;
        next_live[socket_regs_pkg::LS_PWR]   = pwr_is_up;
        next_live[socket_regs_pkg::LS_CD2]   = pins_sync.cd2_n;
        next_live[socket_regs_pkg::LS_CD1]   = pins_sync.cd1_n;
        next_live[socket_regs_pkg::LS_CSTS]  = pins_sync.cstschg;
    end

    // live state register; bus writes never reach it
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            live_state <= socket_regs_pkg::LS_RESET;
        else
            live_state <= next_live;
    end

    // primed stays low until live holds synchronised pins; without it
    // the jump from the reset word to the first real pins reads as events
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            warm <= 2'h0;
        else if (warm != socket_regs_pkg::SYNC_FILL)
            warm <= 2'(warm + 2'h1);
    end

    // high once two synchronised live words are compared
    assign primed = (warm == socket_regs_pkg::SYNC_FILL);

    // hardware event sets: power pulse, and pin changes against the previous live value
    always_comb
    begin
        ev_set = 4'h0;
        ev_set[socket_regs_pkg::EV_PWR]  = pwr_cycle_done;
        ev_set[socket_regs_pkg::EV_CD2]  = primed &
            (next_live[socket_regs_pkg::LS_CD2] !=
             live_state[socket_regs_pkg::LS_CD2]);
        ev_set[socket_regs_pkg::EV_CD1]  = primed &
            (next_live[socket_regs_pkg::LS_CD1] !=
             live_state[socket_regs_pkg::LS_CD1]);
        ev_set[socket_regs_pkg::EV_CSTS] = primed &
            (next_live[socket_regs_pkg::LS_CSTS] !=
             live_state[socket_regs_pkg::LS_CSTS]);
    end

    // a detect pin rising means the card was pulled out
    assign removal = primed &
        ((next_live[socket_regs_pkg::LS_CD1] &
          ~live_state[socket_regs_pkg::LS_CD1]) |
         (next_live[socket_regs_pkg::LS_CD2] &
          ~live_state[socket_regs_pkg::LS_CD2]));

    // software clear mask from a write of ones
    assign ev_clr = (wr_acc && hit(paddr, socket_regs_pkg::OFF_EVENT)) ?
                    pwdata[3:0] : 4'h0;

    // event flags: set wins over a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            event_flags <= socket_regs_pkg::EV_RESET[3:0];
        else
            event_flags <= (event_flags & ~ev_clr) | ev_set;
    end

    // interrupt enables; removal clears bit 0 over any write
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            irq_en <= socket_regs_pkg::EN_RESET;
        else
        begin
            if (wr_acc && hit(paddr, socket_regs_pkg::OFF_ENABLE))
                irq_en <= pwdata[3:0];
            if (removal)
                irq_en[socket_regs_pkg::EV_CSTS] <= 1'b0;
        end
    end

    // per-event gate; detect pair opens only on code 11
    always_comb
    begin
        logic cd_on;
        cd_on = (irq_en[2:1] == socket_regs_pkg::EN_CD_ON);
        irq_gate = {irq_en[socket_regs_pkg::EV_PWR],
                    cd_on, cd_on,
                    irq_en[socket_regs_pkg::EV_CSTS]};
    end

    // status changed interrupt, registered
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            status_irq <= 1'b0;
        else
            status_irq <= |(event_flags & irq_gate);
    end

    // 5v switch: only for a card that accepts 5v and is not cardbus
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            vcc_5v_en <= 1'b0;
        else
            vcc_5v_en <= vcc_5v_req & ~cardbus_card &
                         next_live[socket_regs_pkg::LS_CARD5];
    end

    // read data captured in setup, stands through the access phase
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (setup)
        begin
            if (hit(paddr, socket_regs_pkg::OFF_EVENT))
                prdata <= {28'h0000_000, event_flags};
            else if (hit(paddr, socket_regs_pkg::OFF_ENABLE))
                prdata <= {28'h0000_000, irq_en};
            else if (hit(paddr, socket_regs_pkg::OFF_LIVE))
                prdata <= live_state;
            else
                prdata <= 32'h0000_0000;
        end
    end

    // error for addresses outside the register space
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            pslverr <= 1'b0;
        else if (setup)
            pslverr <= !mapped(paddr);
    end

    // checks on the block's own registers and outputs
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // a one-cycle power pulse sets its flag
    pwr_event_set_a: assert property (
        pwr_cycle_done |=> event_flags[socket_regs_pkg::EV_PWR])
        else $error("power cycle event not latched");

    // a settled second detect change sets its flag
    cd2_event_set_a: assert property (
        $changed(live_state[socket_regs_pkg::LS_CD2]) && $past(primed)
        |-> event_flags[socket_regs_pkg::EV_CD2])
        else $error("second detect change not latched");

    // a settled first detect change sets its flag
    cd1_event_set_a: assert property (
        $changed(live_state[socket_regs_pkg::LS_CD1]) && $past(primed)
        |-> event_flags[socket_regs_pkg::EV_CD1])
        else $error("first detect change not latched");

    // a settled status pin change sets its flag
    csts_event_set_a: assert property (
        $changed(live_state[socket_regs_pkg::LS_CSTS]) && $past(primed)
        |-> event_flags[socket_regs_pkg::EV_CSTS])
        else $error("status change not latched");

    // a one written to bit 3 with no power pulse clears the power flag
    event_w1c_a: assert property (
        wr_acc && hit(paddr, socket_regs_pkg::OFF_EVENT) && pwdata[3]
        && !pwr_cycle_done |=> !event_flags[socket_regs_pkg::EV_PWR])
        else $error("event flag not cleared by write of one");

    // a zero written to a set flag leaves it set
    event_w0_keep_a: assert property (
        wr_acc && hit(paddr, socket_regs_pkg::OFF_EVENT)
        |=> ($past(event_flags) & ~$past(pwdata[3:0]) & ~event_flags)
            == 4'h0)
        else $error("flag lost on a write of zero");

    // event reads carry zeros above the four flags
    event_rsv_zero_a: assert property (
        pready && !pwrite && hit(paddr, socket_regs_pkg::OFF_EVENT)
        |-> prdata[31:4] == 28'h0000_000)
        else $error("reserved event bits read nonzero");

    // no interrupt without an enabled event behind it
    irq_cause_a: assert property (
        status_irq |-> $past(|(event_flags & irq_gate)))
        else $error("interrupt without enabled event");

    // interrupt worked out afresh from flags and enables
    irq_rule_a: assert property (
        1'b1 |=> status_irq == $past(
            (event_flags[socket_regs_pkg::EV_PWR] &
             irq_en[socket_regs_pkg::EV_PWR]) |
            (event_flags[socket_regs_pkg::EV_CSTS] &
             irq_en[socket_regs_pkg::EV_CSTS]) |
            ((|event_flags[2:1]) &
             (irq_en[2:1] == socket_regs_pkg::EN_CD_ON))))
        else $error("interrupt differs from enabled events");

    // pulling the card drops the status change enable
    removal_clears_en_a: assert property (
        removal |=> !irq_en[socket_regs_pkg::EV_CSTS])
        else $error("removal left enable bit 0 set");

    // enable reads carry zeros above the four enables
    enable_rsv_zero_a: assert property (
        pready && !pwrite && hit(paddr, socket_regs_pkg::OFF_ENABLE)
        |-> prdata[31:4] == 28'h0000_000)
        else $error("reserved enable bits read nonzero");

    // reserved live bits stay zero
    live_rsv_zero_a: assert property (
        (live_state & 32'hcfff_f3f0) == 32'h0000_0000)
        else $error("reserved live bits nonzero");

    // live detect and status bits follow the synchronised pins
    live_pins_a: assert property (
        primed |-> live_state[2:0] ==
            $past({pins_sync.cd2_n, pins_sync.cd1_n, pins_sync.cstschg}))
        else $error("live pin bits differ from pins");

    // live supply bits follow the socket inputs one edge later
    live_caps_a: assert property (
        primed |-> live_state[socket_regs_pkg::LS_CAP3] ==
                   $past(sock_cap_3v3) &&
                   live_state[socket_regs_pkg::LS_CAP5] ==
                   $past(sock_cap_5v))
        else $error("live supply bits differ from inputs");

    // a cardbus card never reads as 5v capable
    card5_cardbus_a: assert property (
        cardbus_card |=> !live_state[socket_regs_pkg::LS_CARD5])
        else $error("5v card bit set for a cardbus card");

    // the 5v switch stays off for a cardbus card
    no_5v_cardbus_a: assert property (
        $past(cardbus_card) |-> !vcc_5v_en)
        else $error("5v enabled for a cardbus card");

    // addresses past the map answer with an error
    pslverr_map_a: assert property (
        setup && paddr > socket_regs_pkg::OFF_CLK |=> pslverr)
        else $error("no error for an unmapped address");

    // main scenarios: insertion, interrupt, collision, removal, masked latch
    insert_cover_c: cover property (
        $fell(live_state[socket_regs_pkg::LS_CD1]) && primed);
    irq_fire_c: cover property ($rose(status_irq));
    set_clear_c: cover property (|(ev_set & ev_clr));
    removal_c: cover property (removal && irq_en[0]);
    masked_latch_c: cover property (
        $changed(live_state[socket_regs_pkg::LS_CD1]) &&
        irq_en[2:1] == 2'h0);

endmodule : socket_event_regs

// ==== bench/card_model.sv ====
// card model: drives the socket connector pins for a card or empty slot
module card_model
(
    // card controls from the bench
    input  wire logic                   present,
    input  wire logic                   volt_3v3,
    input  wire logic                   volt_5v,
    input  wire logic                   sts_req,
    // connector pins
    output socket_regs_pkg::card_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // empty slot: detect and sense pulled up, status pulled down
    always_comb
    begin
        pins.cd1_n   = !present;                   // detect low
        pins.cd2_n   = !present;                   // detect low
        pins.cstschg = present & sts_req;          // status pin
        pins.vs1     = present ? !volt_3v3 : 1'b1; // 3.3v sense
        pins.vs2     = present ? volt_5v : 1'b1;   // 5v sense
    end
endmodule : card_model

// ==== bench/testbench.sv ====
// testbench: socket register bank against a behavioural socket model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset, apb and socket side stimulus
    logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pwr_done = 1'b0, pwr_up = 1'b0, cb = 1'b0;
    logic        cap3 = 1'b0, cap5 = 1'b0, req5 = 1'b0, pres = 1'b0;
    logic        v3 = 1'b0, v5 = 1'b0, sts = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, irq, en5;
    socket_regs_pkg::card_pins_t pins;
    int          n_errors = 0, num_checks = 0, cycles = 0;
    int          ev = 0, en = 0, old_live = 0; // behavioural model

    always #20 clk_sys = ~clk_sys;

    card_model card (.present(pres), .volt_3v3(v3), .volt_5v(v5),
                     .sts_req(sts), .pins(pins));
    socket_event_regs uut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .pwr_cycle_done(pwr_done), .pwr_is_up(pwr_up), .sock_cap_3v3(cap3),
        .sock_cap_5v(cap5), .cardbus_card(cb), .vcc_5v_req(req5),
        .status_irq(irq), .vcc_5v_en(en5));

    // compare one result and count it
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1);
        chk("wait", 1, n); // zero wait states
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // read and compare, no error expected
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd); // read data
        chk("rd_err", 0, err); // mapped read
    endtask : rchk

    // live word expected from the pins and socket inputs
    function automatic int exp_live();
        logic c;
        c = !pins.cd1_n && !pins.cd2_n;
        return {2'b0, cap3, cap5, 16'h0, c & !pins.vs1,
                c & pins.vs2 & !cb, 6'h0, pwr_up, pins.cd2_n,
                pins.cd1_n, pins.cstschg};
    endfunction : exp_live

    // interrupt expected from model flags and enables
    function automatic logic irq_exp();
        return (ev[3] & en[3]) | (ev[0] & en[0]) |
               (ev[2:1] != 2'b00 && en[2:1] == 2'b11);
    endfunction : irq_exp

    // let one edge land, then compare outputs and the event, enable and live registers
    task automatic check();
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("irq", irq_exp(), irq); // gated or
        chk("vcc5", old_live[10] & req5, en5); // 5v gate
        rchk(8'h00, ev, "event"); // flags
        rchk(8'h04, en, "enable"); // enables
        rchk(8'h08, old_live, "live"); // state
    endtask : check

    // write and mirror in the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("wr_err", 0, err); // mapped write
        if (a == 8'h00)
            ev &= ~d;
        if (a == 8'h04)
            en = d & 32'hf;
        check();
    endtask : wr

    // wait for pins to land, then update model events
    task automatic settle();
        int nl;
        repeat (6) @(posedge clk_sys);
        nl = exp_live();
        for (int b = 0; b < 3; b++)
            if (nl[b] != old_live[b])
                ev |= 1 << b; // pin change
        if ((nl[2:1] & ~old_live[2:1]) != 0)
            en &= ~1; // removal
        old_live = nl;
        check();
    endtask : settle

    // print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hdebc9a29));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        old_live = exp_live();
        check(); // after reset
        repeat (3) wr(8'h04, $urandom()); // upper bits
        wr(8'h04, 32'h0);
        {cap3, cap5, pwr_up} <= 3'($urandom());
        {pres, v3, v5, req5} <= 4'hf;
        settle(); // insert masked
        wr(8'h04, 32'h2); // half code
        wr(8'h04, 32'h6); // detect on
        wr(8'h00, 32'h6); // handled
        @(posedge clk_sys);
        pwr_done <= 1'b1;
        @(posedge clk_sys);
        pwr_done <= 1'b0;
        ev |= 8;
        check(); // power done
        wr(8'h04, 32'hf); // power on
        wr(8'h00, 32'h8);
        sts <= 1'b1;
        settle(); // status on
        wr(8'h04, 32'he);
        sts <= 1'b0;
        settle(); // status masked
        wr(8'h00, 32'h1);
        cb <= 1'b1;
        settle(); // cardbus
        wr(8'h08, 32'hffff_ffff); // read only
        for (int a = socket_regs_pkg::OFF_SIM; a < socket_regs_pkg::OFF_CLK;
             a += 4)
            rchk(8'(a), 0, "silent"); // spare map
        rchk(socket_regs_pkg::OFF_CLK, 0, "clk"); // spare map
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped_err", 1, err); // outside map
        wr(8'h04, 32'hf);
        pres <= 1'b0;
        settle(); // removal
        rstn <= 1'b0; // second reset with the socket empty
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ev = 0;
        en = 0;
        check(); // flags and enables cleared
        repeat (4)
        begin
            {pres, v3, v5, sts, cb, req5, cap3, cap5} <= 8'($urandom());
            settle(); // mixed
            wr(8'h00, $urandom()); // partial clear
        end
        conclude();
    end
endmodule : testbench
